/* rtl/imc_pkg.sv */
// shared constants for the interrupt controller
package imc_pkg;
    localparam int NUM_SRC = 15;
    localparam int NUM_LINES = 12;
    localparam int IDX_W = 4;

    // register byte offsets
    localparam logic [7:0] OFF_EN_BASIC = 8'ha8;
    localparam logic [7:0] OFF_LVL_BASIC = 8'hb8;
    localparam logic [7:0] OFF_FLAG_BASIC = 8'hc0;
    localparam logic [7:0] OFF_FLAG_EXT = 8'hc4;
    localparam logic [7:0] OFF_LOCAL = 8'hc8;
    localparam logic [7:0] OFF_STATUS = 8'hcc;
    localparam logic [7:0] OFF_EXT_CTRL = 8'hd8;
    localparam logic [7:0] OFF_EN_EXT = 8'he8;
    localparam logic [7:0] OFF_LVL_EXT = 8'hf8;

    // bits that read as constant ones
    localparam logic [7:0] EN_EXT_ONES = 8'he0;
    localparam logic [7:0] LVL_BASIC_ONES = 8'h80;
    localparam logic [7:0] LVL_EXT_ONES = 8'he0;
    localparam logic [7:0] FLAG_EXT_ONES = 8'h08;
    localparam logic [7:0] EXT_CTRL_ONES = 8'h40;

    // field positions
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_RATE_DOUBLE = 7;
    localparam int BIT_FD_EN = 5;
    localparam int BIT_FD_FLAG = 4;
    localparam int BIT_RTC_FLAG = 3;
    localparam int BIT_T3_FLAG = 7;
    localparam int BIT_CC_FLAG = 6;
    localparam int BIT_T2_FLAG = 5;
    localparam int BIT_RADIO_FLAG = 4;
    localparam int BIT_CONV_FLAG = 0;
    localparam int BIT_CONV_EN = 1;
    localparam int BIT_CIPH_FLAG = 2;
    localparam int BIT_CIPH_EN = 3;

    // source indices
    localparam int SRC_FD = 0;
    localparam int SRC_EXT0 = 1;
    localparam int SRC_T0 = 2;
    localparam int SRC_EXT1 = 3;
    localparam int SRC_T1 = 4;
    localparam int SRC_S0TX = 5;
    localparam int SRC_S0RX = 6;
    localparam int SRC_S1TX = 7;
    localparam int SRC_S1RX = 8;
    localparam int SRC_RADIO = 9;
    localparam int SRC_T2 = 10;
    localparam int SRC_CONV = 11;
    localparam int SRC_CIPH = 12;
    localparam int SRC_T3 = 13;
    localparam int SRC_RTC = 14;

    // reset values
    localparam logic [7:0] RST_EN_BASIC = 8'h00;
    localparam logic [4:0] RST_EN_EXT = 5'h00;
    localparam logic [6:0] RST_LVL_BASIC = 7'h00;
    localparam logic [4:0] RST_LVL_EXT = 5'h00;
    localparam logic [7:0] RST_VECTOR = 8'h00;

    // priority levels, 0 means nothing in service
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_TOP = 2'h3;

    // vector per line, index is natural priority
    localparam logic [NUM_LINES-1:0][7:0] LINE_VECTOR = {
        8'h63, 8'h5b, 8'h53, 8'h4b, 8'h43, 8'h3b,
        8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03, 8'h33};

    typedef enum logic [0:0] {
        BUS_ANSWER = 1'b0,
        BUS_WAIT = 1'b1
    } imc_bus_e;
endpackage

/* rtl/imc_arbiter.sv */
// picks the winning line by level then natural priority
`timescale 1ns/10ps
`default_nettype none
module imc_arbiter #(
    parameter int NLINES = 12
) (
    input wire logic [NLINES-1:0] lineReq,
    input wire logic [NLINES-1:0][1:0] lineLvl,
    input wire logic [1:0] ceilLvl,
    output logic grant,
    output logic [imc_pkg::IDX_W-1:0] grantIdx,
    output logic [1:0] grantLvl
);
    always_comb begin
        grant = 1'b0;
        grantIdx = '0;
        grantLvl = imc_pkg::LVL_NONE;
        // walk down so a lower index wins a tie
        for (int i = NLINES - 1; i >= 0; i--) begin
            if (lineReq[i] && lineLvl[i] > ceilLvl &&
                (!grant || lineLvl[i] >= grantLvl)) begin
                grant = 1'b1;
                grantIdx = imc_pkg::IDX_W'(i);
                grantLvl = lineLvl[i];
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/imc_controller.sv */
// interrupt controller top with avalon register slave
// Functional notes
// RQ1: fifteen sources feed twelve vectored lines, some lines shared.
// RQ2: ext0, timer0, ext1, timer1 vectors 0x03, 0x0B, 0x13, 0x1B.
// RQ3: flash/debug uses vector 0x33, natural priority 0, no level control.
// RQ4: serial zero tx or rx raise one line, vector 0x23, priority 5.
// RQ5: serial one tx or rx share line, vector 0x3B, priority 6.
// RQ6: radio line uses vector 0x43, priority 7, extended enable and flag.
// RQ7: converter and cipher share 0x53, each needs local and shared enable.
// RQ8: timer two 0x4B/8, timer three 0x5B/10, clock alarm 0x63/11.
// RQ9: ext and timer zero/one flags clear by hardware when serviced.
// RQ10: global enable gates every line except flash/debug.
// RQ11: flash/debug gated only by its own enable.
// RQ12: basic enable register layout, global at bit 7, all reset zero.
// RQ13: extended enable layout, bits 7 to 5 read one.
// RQ14: software setting a flag requests like a hardware event.
// RQ15: a running routine is preempted only by a higher level.
// RQ16: routines end with return; in-service level is then released.
// RQ17: interrupts are taken only at instruction boundaries.
// RQ18: after return or enable/level write, one more instruction first.
// RQ19: flash/debug flag at bit 4 set by flash write or trap, software clears.
// RQ20: clock alarm flag at bit 3 set by request or software.
// RQ21: flash/debug enable at bit 5, bit 6 reads one, bits 2-0 zero.
// RQ22: bit 7 of extended control doubles serial one rate.
// RQ23: equal level ties go to the lowest natural priority number.
// RQ24: only a strictly higher level preempts; flash/debug alone is top.
// RQ25: requests sampled at boundaries, vector given with an acknowledge.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module imc_controller (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [imc_pkg::NUM_SRC-1:0] srcEvent,
    input wire logic instrDone,
    input wire logic instrIsReturn,
    output logic serviceAck,
    output logic [7:0] serviceVector,
    output logic serialOneRateDouble
);
    imc_pkg::imc_bus_e busState_reg;
    logic [31:0] readData_reg;
    logic [7:0] enBasic_reg;
    logic [4:0] enExt_reg;
    logic [6:0] lvlBasic_reg;
    logic [4:0] lvlExt_reg;
    logic rateDouble_reg;
    logic fdEnable_reg;
    logic convLocalEn_reg;
    logic cipherLocalEn_reg;
    logic [imc_pkg::NUM_SRC-1:0] flag_reg;
    logic convCipherFlag_reg;
    logic cfgWrote_reg;
    logic [2:0] inServ_reg;
    logic serviceAck_reg;
    logic [7:0] serviceVector_reg;

    logic wrStrobe;
    logic [7:0] wd;
    logic cfgWriteNow;
    logic [imc_pkg::NUM_SRC-1:0] swWe;
    logic [imc_pkg::NUM_SRC-1:0] swVal;
    logic [imc_pkg::NUM_SRC-1:0] hwClr;
    logic convCipherSet;
    logic globalEn;
    logic [imc_pkg::NUM_LINES-1:0] lineReq;
    logic [imc_pkg::NUM_LINES-1:0] lineHigh;
    logic [imc_pkg::NUM_LINES-1:0][1:0] lineLvl;
    logic [1:0] ceilLvl;
    logic grant;
    logic [imc_pkg::IDX_W-1:0] grantIdx;
    logic [1:0] grantLvl;
    logic take;
    logic retire;
    logic [31:0] rdMux;

    // bus handshake: one wait cycle, then the answer edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busState_reg <= imc_pkg::BUS_WAIT;
        end else if (ce) begin
            case (busState_reg)
                imc_pkg::BUS_WAIT: begin
                    if (avs_read || avs_write) begin
                        busState_reg <= imc_pkg::BUS_ANSWER;
                    end
                end
                imc_pkg::BUS_ANSWER: begin
                    busState_reg <= imc_pkg::BUS_WAIT;
                end
                default: begin
                    busState_reg <= imc_pkg::BUS_WAIT;
                end
            endcase
        end
    end

    assign avs_waitrequest = busState_reg[0];
    assign avs_readdata = readData_reg;
    assign wrStrobe = ce && avs_write && avs_byteenable[0] &&
        busState_reg == imc_pkg::BUS_ANSWER;
    assign wd = avs_writedata[7:0];
    assign cfgWriteNow = wrStrobe &&
        (avs_address == imc_pkg::OFF_EN_BASIC ||
         avs_address == imc_pkg::OFF_EN_EXT ||
         avs_address == imc_pkg::OFF_LVL_BASIC ||
         avs_address == imc_pkg::OFF_LVL_EXT);

    // enable, level and control registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enBasic_reg <= imc_pkg::RST_EN_BASIC;
            enExt_reg <= imc_pkg::RST_EN_EXT;
            lvlBasic_reg <= imc_pkg::RST_LVL_BASIC;
            lvlExt_reg <= imc_pkg::RST_LVL_EXT;
            rateDouble_reg <= 1'b0;
            fdEnable_reg <= 1'b0;
            convLocalEn_reg <= 1'b0;
            cipherLocalEn_reg <= 1'b0;
        end else if (wrStrobe) begin
            if (avs_address == imc_pkg::OFF_EN_BASIC) begin
                enBasic_reg <= wd; // see RQ12
            end else if (avs_address == imc_pkg::OFF_EN_EXT) begin
                enExt_reg <= wd[4:0]; // see RQ13
            end else if (avs_address == imc_pkg::OFF_LVL_BASIC) begin
                lvlBasic_reg <= wd[6:0];
            end else if (avs_address == imc_pkg::OFF_LVL_EXT) begin
                lvlExt_reg <= wd[4:0];
            end else if (avs_address == imc_pkg::OFF_EXT_CTRL) begin
                rateDouble_reg <= wd[imc_pkg::BIT_RATE_DOUBLE]; // see RQ22
                fdEnable_reg <= wd[imc_pkg::BIT_FD_EN]; // see RQ21
            end else if (avs_address == imc_pkg::OFF_LOCAL) begin
                convLocalEn_reg <= wd[imc_pkg::BIT_CONV_EN];
                cipherLocalEn_reg <= wd[imc_pkg::BIT_CIPH_EN];
            end
        end
    end

    assign serialOneRateDouble = rateDouble_reg;

    // software writes that reach each flag
    always_comb begin
        swWe = '0;
        swVal = '0;
        if (wrStrobe) begin
            if (avs_address == imc_pkg::OFF_FLAG_BASIC) begin
                swWe[imc_pkg::SRC_S1RX:imc_pkg::SRC_EXT0] = '1;
                swVal[imc_pkg::SRC_S1RX:imc_pkg::SRC_EXT0] = wd;
            end else if (avs_address == imc_pkg::OFF_FLAG_EXT) begin
                swWe[imc_pkg::SRC_T3] = 1'b1;
                swVal[imc_pkg::SRC_T3] = wd[imc_pkg::BIT_T3_FLAG];
                swWe[imc_pkg::SRC_T2] = 1'b1;
                swVal[imc_pkg::SRC_T2] = wd[imc_pkg::BIT_T2_FLAG];
                swWe[imc_pkg::SRC_RADIO] = 1'b1;
                swVal[imc_pkg::SRC_RADIO] = wd[imc_pkg::BIT_RADIO_FLAG];
            end else if (avs_address == imc_pkg::OFF_EXT_CTRL) begin
                swWe[imc_pkg::SRC_FD] = 1'b1; // see RQ19
                swVal[imc_pkg::SRC_FD] = wd[imc_pkg::BIT_FD_FLAG];
                swWe[imc_pkg::SRC_RTC] = 1'b1; // see RQ20
                swVal[imc_pkg::SRC_RTC] = wd[imc_pkg::BIT_RTC_FLAG];
            end else if (avs_address == imc_pkg::OFF_LOCAL) begin
                swWe[imc_pkg::SRC_CONV] = 1'b1;
                swVal[imc_pkg::SRC_CONV] = wd[imc_pkg::BIT_CONV_FLAG];
                swWe[imc_pkg::SRC_CIPH] = 1'b1;
                swVal[imc_pkg::SRC_CIPH] = wd[imc_pkg::BIT_CIPH_FLAG];
            end
        end
    end

    // taking ext/timer zero/one lines clears their flag
    always_comb begin
        hwClr = '0;
        if (take && grantIdx >= imc_pkg::IDX_W'(imc_pkg::SRC_EXT0) &&
            grantIdx <= imc_pkg::IDX_W'(imc_pkg::SRC_T1)) begin
            hwClr[grantIdx] = 1'b1; // see RQ9
        end
    end

    // per-source flags; a hardware event beats a clear
    for (genvar i = 0; i < imc_pkg::NUM_SRC; i++) begin : g_flag
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                flag_reg[i] <= 1'b0;
            end else if (ce) begin
                if (srcEvent[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (swWe[i]) begin
                    flag_reg[i] <= swVal[i]; // see RQ14
                end else if (hwClr[i]) begin
                    flag_reg[i] <= 1'b0;
                end
            end
        end
    end

    // shared converter/cipher flag set by gated local flags, cleared only by software
    assign convCipherSet =
        (flag_reg[imc_pkg::SRC_CONV] && convLocalEn_reg) ||
        (flag_reg[imc_pkg::SRC_CIPH] && cipherLocalEn_reg); // see RQ7

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            convCipherFlag_reg <= 1'b0;
        end else if (ce) begin
            if (convCipherSet) begin
                convCipherFlag_reg <= 1'b1;
            end else if (wrStrobe &&
                avs_address == imc_pkg::OFF_FLAG_EXT) begin
                convCipherFlag_reg <= wd[imc_pkg::BIT_CC_FLAG];
            end
        end
    end

    // line requests, index equals natural priority
    assign globalEn = enBasic_reg[imc_pkg::BIT_GLOBAL_EN]; // see RQ10

    always_comb begin
        lineReq[0] = fdEnable_reg && flag_reg[imc_pkg::SRC_FD]; // see RQ11
        lineReq[1] = enBasic_reg[0] && flag_reg[imc_pkg::SRC_EXT0];
        lineReq[2] = enBasic_reg[1] && flag_reg[imc_pkg::SRC_T0];
        lineReq[3] = enBasic_reg[2] && flag_reg[imc_pkg::SRC_EXT1];
        lineReq[4] = enBasic_reg[3] && flag_reg[imc_pkg::SRC_T1];
        lineReq[5] = enBasic_reg[4] && (flag_reg[imc_pkg::SRC_S0TX] ||
            flag_reg[imc_pkg::SRC_S0RX]); // see RQ4
        lineReq[6] = enBasic_reg[6] && (flag_reg[imc_pkg::SRC_S1TX] ||
            flag_reg[imc_pkg::SRC_S1RX]); // see RQ5
        lineReq[7] = enExt_reg[0] && flag_reg[imc_pkg::SRC_RADIO]; // see RQ6
        lineReq[8] = enExt_reg[1] && flag_reg[imc_pkg::SRC_T2]; // see RQ8
        lineReq[9] = enExt_reg[2] && convCipherFlag_reg; // see RQ7
        lineReq[10] = enExt_reg[3] && flag_reg[imc_pkg::SRC_T3];
        lineReq[11] = enExt_reg[4] && flag_reg[imc_pkg::SRC_RTC];
        lineReq[imc_pkg::NUM_LINES-1:1] =
            lineReq[imc_pkg::NUM_LINES-1:1] & {11{globalEn}}; // see RQ10
    end

    // level select bits per line
    assign lineHigh = {lvlExt_reg, lvlBasic_reg[6], lvlBasic_reg[4:0],
        1'b0};

    always_comb begin
        lineLvl[0] = imc_pkg::LVL_TOP; // see RQ24
        for (int i = 1; i < imc_pkg::NUM_LINES; i++) begin
            lineLvl[i] = lineHigh[i] ? imc_pkg::LVL_HIGH : imc_pkg::LVL_LOW;
        end
    end

    // highest level now in service
    always_comb begin
        if (inServ_reg[2]) begin
            ceilLvl = imc_pkg::LVL_TOP;
        end else if (inServ_reg[1]) begin
            ceilLvl = imc_pkg::LVL_HIGH;
        end else if (inServ_reg[0]) begin
            ceilLvl = imc_pkg::LVL_LOW;
        end else begin
            ceilLvl = imc_pkg::LVL_NONE;
        end
    end

    imc_arbiter #(
        .NLINES(imc_pkg::NUM_LINES)
    ) u_arbiter (
        .lineReq(lineReq),
        .lineLvl(lineLvl),
        .ceilLvl(ceilLvl),
        .grant(grant),
        .grantIdx(grantIdx),
        .grantLvl(grantLvl)
    ); // see RQ15 see RQ23

    // boundary sampling with one-instruction holdoff
    assign take = ce && instrDone && grant && !instrIsReturn &&
        !cfgWrote_reg && !cfgWriteNow; // see RQ17 see RQ18 see RQ25
    assign retire = ce && instrDone && instrIsReturn; // see RQ16

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfgWrote_reg <= 1'b0;
        end else if (ce) begin
            if (instrDone) begin
                cfgWrote_reg <= 1'b0;
            end else if (cfgWriteNow) begin
                cfgWrote_reg <= 1'b1; // see RQ18
            end
        end
    end

    // in-service levels, bit n is level n+1
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            inServ_reg <= 3'h0;
        end else if (take) begin
            inServ_reg[grantLvl - 2'h1] <= 1'b1; // see RQ15
        end else if (retire) begin
            if (inServ_reg[2]) begin
                inServ_reg[2] <= 1'b0;
            end else if (inServ_reg[1]) begin
                inServ_reg[1] <= 1'b0;
            end else begin
                inServ_reg[0] <= 1'b0;
            end
        end
    end

    // vector and acknowledge to the sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            serviceAck_reg <= 1'b0;
            serviceVector_reg <= imc_pkg::RST_VECTOR;
        end else if (ce) begin
            serviceAck_reg <= take;
            if (take) begin
                serviceVector_reg <= imc_pkg::LINE_VECTOR[grantIdx]; // see RQ2
            end
        end
    end

    assign serviceAck = serviceAck_reg;
    assign serviceVector = serviceVector_reg; // see RQ1 see RQ3

    // register read mux
    always_comb begin
        rdMux = 32'h0;
        if (avs_address == imc_pkg::OFF_EN_BASIC) begin
            rdMux[7:0] = enBasic_reg;
        end else if (avs_address == imc_pkg::OFF_EN_EXT) begin
            rdMux[7:0] = imc_pkg::EN_EXT_ONES | {3'h0, enExt_reg}; // see RQ13
        end else if (avs_address == imc_pkg::OFF_LVL_BASIC) begin
            rdMux[7:0] = imc_pkg::LVL_BASIC_ONES | {1'b0, lvlBasic_reg};
        end else if (avs_address == imc_pkg::OFF_LVL_EXT) begin
            rdMux[7:0] = imc_pkg::LVL_EXT_ONES | {3'h0, lvlExt_reg};
        end else if (avs_address == imc_pkg::OFF_EXT_CTRL) begin
            rdMux[7:0] = imc_pkg::EXT_CTRL_ONES; // see RQ21
            rdMux[imc_pkg::BIT_RATE_DOUBLE] = rateDouble_reg;
            rdMux[imc_pkg::BIT_FD_EN] = fdEnable_reg;
            rdMux[imc_pkg::BIT_FD_FLAG] = flag_reg[imc_pkg::SRC_FD];
            rdMux[imc_pkg::BIT_RTC_FLAG] = flag_reg[imc_pkg::SRC_RTC];
        end else if (avs_address == imc_pkg::OFF_FLAG_BASIC) begin
            rdMux[7:0] = flag_reg[imc_pkg::SRC_S1RX:imc_pkg::SRC_EXT0];
        end else if (avs_address == imc_pkg::OFF_FLAG_EXT) begin
            rdMux[7:0] = imc_pkg::FLAG_EXT_ONES;
            rdMux[imc_pkg::BIT_T3_FLAG] = flag_reg[imc_pkg::SRC_T3];
            rdMux[imc_pkg::BIT_CC_FLAG] = convCipherFlag_reg;
            rdMux[imc_pkg::BIT_T2_FLAG] = flag_reg[imc_pkg::SRC_T2];
            rdMux[imc_pkg::BIT_RADIO_FLAG] = flag_reg[imc_pkg::SRC_RADIO];
        end else if (avs_address == imc_pkg::OFF_LOCAL) begin
            rdMux[imc_pkg::BIT_CONV_FLAG] = flag_reg[imc_pkg::SRC_CONV];
            rdMux[imc_pkg::BIT_CONV_EN] = convLocalEn_reg;
            rdMux[imc_pkg::BIT_CIPH_FLAG] = flag_reg[imc_pkg::SRC_CIPH];
            rdMux[imc_pkg::BIT_CIPH_EN] = cipherLocalEn_reg;
        end else if (avs_address == imc_pkg::OFF_STATUS) begin
            rdMux[2:0] = inServ_reg;
            rdMux[15:8] = serviceVector_reg;
        end
    end

    // read data captured in the wait cycle, stands at the answer edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            readData_reg <= 32'h0;
        end else if (ce && avs_read &&
            busState_reg == imc_pkg::BUS_WAIT) begin
            readData_reg <= rdMux;
        end
    end
endmodule
`default_nettype wire

/* verif/imc_controller_props.sv */
// assertion checker for the interrupt controller ports
`timescale 1ns/10ps
`default_nettype none
module imc_controller_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic instrIsReturn,
    input wire logic instrDone,
    input wire logic serviceAck,
    input wire logic [7:0] serviceVector,
    input wire logic serialOneRateDouble
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic ctlWr;
    assign ctlWr = ce && avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == 8'hd8;
    AST_TAKE_AT_BOUNDARY: assert property
        (serviceAck |-> $past(instrDone && ce))
        else $error("take off an instruction boundary");
    AST_NO_TAKE_ON_RETURN: assert property
        (serviceAck |-> !$past(instrIsReturn))
        else $error("take at a return boundary");
    AST_VECTOR_LEGAL: assert property
        (serviceAck |-> serviceVector inside {8'h33, 8'h03, 8'h0b, 8'h13,
        8'h1b, 8'h23, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63})
        else $error("vector not in table");
    AST_VECTOR_HOLDS: assert property
        (!serviceAck |-> $stable(serviceVector))
        else $error("vector moved without a take");
    AST_ONE_WAIT: assert property
        ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
        else $error("bus answer not after one wait");
    AST_WAIT_PULSE: assert property
        (ce && !avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    AST_NO_IDLE_ANSWER: assert property
        (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    AST_RATE_WRITE: assert property
        (ctlWr |=> serialOneRateDouble == $past(avs_writedata[7]))
        else $error("rate double not written");
    AST_RATE_HOLD: assert property
        (!ctlWr |=> $stable(serialOneRateDouble))
        else $error("rate double changed by itself");
endmodule
bind imc_controller imc_controller_props u_props (.clk_sys, .rst, .ce,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_waitrequest, .instrIsReturn, .instrDone, .serviceAck,
    .serviceVector, .serialOneRateDouble);
`default_nettype wire

/* verif/imc_cpu_model.sv */
// cpu sequencer model: instruction boundaries and returns
`timescale 1ns/10ps
`default_nettype none
module imc_cpu_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic retReq,
    output logic instrDone,
    output logic instrIsReturn
);
    logic [1:0] cnt;
    logic [1:0] len;
    logic retPend;
    logic last;
    assign last = cnt == len;
    // instruction lengths rotate through one to four cycles
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            len <= 2'h0;
        end else if (last) begin
            cnt <= 2'h0;
            len <= len + 2'h1;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            instrDone <= 1'b0;
            instrIsReturn <= 1'b0;
            retPend <= 1'b0;
        end else begin
            instrDone <= last;
            instrIsReturn <= last && (retPend || retReq);
            retPend <= (retPend || retReq) && !last;
        end
    end
endmodule
`default_nettype wire

/* verif/imc_controller_test.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module imc_controller_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [imc_pkg::NUM_SRC-1:0] srcEvent = '0;
    logic instrDone;
    logic instrIsReturn;
    logic retReq = 1'b0;
    logic serviceAck;
    logic [7:0] serviceVector;
    logic serialOneRateDouble;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 15;
    int l;
    int s;
    logic [7:0] q;
    logic [7:0] a;
    logic [7:0] m;
    logic [7:0] d;
    int srcTab[12] = '{0, 1, 2, 3, 4, 5, 7, 9, 10, 11, 13, 14};
    logic [7:0] clrTab[5] = '{8'hc4, 8'hc0, 8'hd8, 8'ha8, 8'he8};
    always #5 clk_sys = ~clk_sys;
    imc_controller u_dut (.clk_sys, .rst, .ce, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .srcEvent, .instrDone,
        .instrIsReturn, .serviceAck, .serviceVector, .serialOneRateDouble);
    imc_cpu_model u_cpu (.clk_sys, .rst, .retReq, .instrDone,
        .instrIsReturn);
    function automatic logic [7:0] vec_of(input int n);
        logic [7:0] t[12] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
            8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
        return t[n];
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(negedge clk_sys) begin
        cycles++;
        if (cycles == 10000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] ad,
        input logic [7:0] dt, input logic [3:0] be);
        @(posedge clk_sys);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= ad;
        avs_writedata <= {24'h0, dt};
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp);
        bus(1'b0, ad, 8'h00, 4'hf);
        chk(q, exp);
    endtask
    task automatic pulse(input logic [imc_pkg::NUM_SRC-1:0] e);
        @(posedge clk_sys) srcEvent <= e;
        @(posedge clk_sys) srcEvent <= '0;
    endtask
    task automatic ret();
        @(posedge clk_sys) retReq <= 1'b1;
        @(posedge clk_sys) retReq <= 1'b0;
    endtask
    task automatic expect_take(input int k, input logic [7:0] v);
        int n;
        n = 0;
        repeat (40) begin
            @(negedge clk_sys);
            if (serviceAck === 1'b1) n++;
        end
        chk(8'(n), 8'(k));
        if (k > 0) chk(serviceVector, v);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(8'ha8, 8'h00);
        rdchk(8'he8, 8'he0);
        rdchk(8'hd8, 8'h40);
        rdchk(8'h10, 8'h00);
        d = 8'($random(seed));
        bus(1'b1, 8'ha8, d, 4'h1);
        bus(1'b1, 8'ha8, ~d, 4'h0);
        rdchk(8'ha8, d);
        bus(1'b1, 8'he8, ~d, 4'h1);
        rdchk(8'he8, ~d | 8'he0);
        d = d & 8'ha0;
        for (l = 0; l < 2; l++) begin
            bus(1'b1, 8'hd8, d | 8'h07, 4'h1);
            rdchk(8'hd8, d | 8'h40);
            chk({7'h0, serialOneRateDouble}, {7'h0, d[7]});
            d = d ^ 8'ha0;
        end
        foreach (clrTab[j]) bus(1'b1, clrTab[j], 8'h00, 4'h1);
        bus(1'b1, 8'hc8, 8'h0a, 4'h1);
        for (l = 0; l < 12; l++) begin
            s = srcTab[l];
            if (l == 5 || l == 6 || l == 9) s = s + ($random(seed) & 1);
            a = l == 0 ? 8'hd8 : l < 7 ? 8'ha8 : 8'he8;
            m = l == 0 ? 8'h20 : l == 6 ? 8'h40
                : l < 7 ? 8'h01 << (l - 1) : 8'h01 << (l - 7);
            bus(1'b1, a, m, 4'h1);
            pulse(15'h1 << s);
            expect_take(l == 0, vec_of(0));
            if (l > 0) begin
                bus(1'b1, 8'ha8, (l < 7 ? m : 8'h00) | 8'h80, 4'h1);
                expect_take(1, vec_of(l));
            end
            if (l > 0 && l < 7)
                rdchk(8'hc0, l < 5 ? 8'h00 : 8'h01 << (s - 1));
            bus(1'b1, 8'hc8, 8'h0a, 4'h1);
            foreach (clrTab[j]) bus(1'b1, clrTab[j], 8'h00, 4'h1);
            ret();
        end
        bus(1'b1, 8'ha8, 8'h83, 4'h1);
        bus(1'b1, 8'hd8, 8'h20, 4'h1);
        pulse(15'h6);
        expect_take(1, 8'h03);
        expect_take(0, 8'h00);
        pulse(15'h1);
        expect_take(1, 8'h33);
        bus(1'b1, 8'hd8, 8'h20, 4'h1);
        ret();
        expect_take(0, 8'h00);
        ret();
        expect_take(1, 8'h0b);
        bus(1'b1, 8'hb8, 8'h08, 4'h1);
        bus(1'b1, 8'ha8, 8'h8b, 4'h1);
        bus(1'b1, 8'hc0, 8'h08, 4'h1);
        expect_take(1, 8'h1b);
        rdchk(8'hcc, 8'h03);
        @(posedge clk_sys) ce <= 1'b0;
        pulse(15'h4000);
        @(posedge clk_sys) ce <= 1'b1;
        rdchk(8'hd8, 8'h60);
        stop_test();
    end
endmodule
`default_nettype wire
